/* epc_defs.svh */
// Constants of the EPP cycle engine: register offsets, field positions,
// reset values and timing counts.
// Assumes inclusion by bare name from the package and the engine top.
`ifndef EPC_DEFS_SVH
`define EPC_DEFS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define EPC_REG_CTRL 8'h00
`define EPC_REG_SPP_DATA 8'h04
`define EPC_REG_CONFIG 8'h08
`define EPC_REG_STATUS 8'h0C
`define EPC_REG_INT_STAT 8'h10
`define EPC_REG_INT_MASK 8'h14
`define EPC_REG_LAST_RD 8'h18
`define EPC_REG_LAST_WR 8'h1C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define EPC_CTRL_STROBE 0
`define EPC_CTRL_LINEFEED 1
`define EPC_CTRL_INIT 2
`define EPC_CTRL_SELECT 3
`define EPC_CTRL_IRQE 4
`define EPC_CTRL_PCD 5
`define EPC_CTRL_MASK 8'h3F
`define EPC_CFG_EPP_EN 0
`define EPC_CFG_V19 1
`define EPC_CFG_MASK 8'h03
`define EPC_STAT_TIMEOUT 0
`define EPC_STAT_BUSY 1
`define EPC_INT_TIMEOUT 0
`define EPC_INT_DONE 1
`define EPC_INT_MASK_BITS 8'h03

// ----------------------------------------
// Host port offsets
// ----------------------------------------
`define EPC_HOST_ADDR_PORT 3'h3
`define EPC_HOST_DATA_FIRST 3'h4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define EPC_CTRL_RST 8'h00
`define EPC_CFG_RST 8'h00
`define EPC_BYTE_RST 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define EPC_CLK_MHZ 125
`define EPC_WDOG_TIME_US 10
`define EPC_WDOG_CYCLES (`EPC_WDOG_TIME_US * `EPC_CLK_MHZ)

`endif

/* epc_pkg.sv */
// Types and decode helpers of the EPP cycle engine.
// Assumes epc_defs.svh is on the include path.
`include "epc_defs.svh"

package epc_pkg;

	typedef enum logic [2:0] {
		EPC_ST_IDLE,
		EPC_ST_R19_WAIT_LOW,
		EPC_ST_R19_SETUP,
		EPC_ST_R19_STROBE,
		EPC_ST_R19_TERM,
		EPC_ST_V17_CYCLE,
		EPC_ST_END_WAIT
	} epc_state_t;

	typedef enum logic [3:0] {
		EPC_R_CTRL,
		EPC_R_SPP_DATA,
		EPC_R_CONFIG,
		EPC_R_STATUS,
		EPC_R_INT_STAT,
		EPC_R_INT_MASK,
		EPC_R_LAST_RD,
		EPC_R_LAST_WR,
		EPC_R_NONE
	} epc_reg_t;

	function automatic epc_reg_t epc_decode(input logic [7:0] adr);
		case (adr)
			`EPC_REG_CTRL: epc_decode = EPC_R_CTRL;
			`EPC_REG_SPP_DATA: epc_decode = EPC_R_SPP_DATA;
			`EPC_REG_CONFIG: epc_decode = EPC_R_CONFIG;
			`EPC_REG_STATUS: epc_decode = EPC_R_STATUS;
			`EPC_REG_INT_STAT: epc_decode = EPC_R_INT_STAT;
			`EPC_REG_INT_MASK: epc_decode = EPC_R_INT_MASK;
			`EPC_REG_LAST_RD: epc_decode = EPC_R_LAST_RD;
			`EPC_REG_LAST_WR: epc_decode = EPC_R_LAST_WR;
			default: epc_decode = EPC_R_NONE;
		endcase
	endfunction

endpackage

/* epc_watchdog.sv */
// Cycle watchdog: counts clocks while a cycle runs, pulses once on expiry.
// Assumes run_i stays high for the whole watched cycle.
`timescale 1ns/10ps
`default_nettype none

module epc_watchdog #(
	parameter int LIMIT = 1250,
	parameter int CW = 16
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Control
	input wire logic run_i,
	output logic expired_o
);

	logic [CW-1:0] count_q;
	logic fired_q;

	// Restarts from zero for every cycle
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || !run_i) begin
			count_q <= '0;
		end else if (!fired_q) begin
			count_q <= count_q + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i || !run_i) begin
			fired_q <= 1'b0;
		end else if (expired_o) begin
			fired_q <= 1'b1;
		end
	end

	assign expired_o = run_i && !fired_q && (count_q == CW'(LIMIT - 1));

endmodule

`default_nettype wire

/* epc_wb_slave.sv */
// Classic Wishbone slave handshake: one wait state, registered read data.
// Assumes the master holds its request until it samples ack.
`timescale 1ns/10ps
`default_nettype none

module epc_wb_slave (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Wishbone
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	output logic ack_o,
	output logic [31:0] dat_o,
	// Register file side
	input wire logic [7:0] rdata_i,
	output logic wr_fire_o,
	output logic rd_fire_o
);

	logic ack_q;

	// Ack drops the cycle after it was given
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= cyc_i && stb_i && !ack_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			dat_o <= 32'h00000000;
		end else if (cyc_i && stb_i && !ack_q && !we_i) begin
			dat_o <= {24'h000000, rdata_i};
		end
	end

	assign ack_o = ack_q;
	// Effects land on the edge where the master samples ack
	assign wr_fire_o = ack_q && cyc_i && stb_i && we_i && sel_i[0];
	assign rd_fire_o = ack_q && cyc_i && stb_i && !we_i;

endmodule

`default_nettype wire

/* epc_engine.sv */
// EPP cycle engine top: host strobe port, peripheral port and register file.
// Assumes all inputs synchronous to MCLK_I; the bench resolves the
// two-way buses from the enables.
`timescale 1ns/10ps
`default_nettype none
`include "epc_defs.svh"

module epc_engine #(
	parameter int WDOG_CYCLES = `EPC_WDOG_CYCLES
) (
	// Clock and reset
	input wire logic MCLK_I,
	input wire logic RSTN_I,
	// Wishbone register bus
	input wire logic [7:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic WB_WE_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	output logic WB_ACK_O,
	output logic [31:0] WB_DAT_O,
	output logic INT_O,
	// Host strobe port
	input wire logic [2:0] HOST_ADDR_I,
	input wire logic HOST_RD_N_I,
	input wire logic HOST_WR_N_I,
	input wire logic [7:0] HOST_DATA_BUS_I,
	output logic [7:0] HOST_DATA_BUS_O,
	output logic HOST_DATA_BUS_OE_O,
	output logic HOST_CHAN_READY_O,
	// Peripheral port
	input wire logic [7:0] PORT_BUS_I,
	output logic [7:0] PORT_BUS_O,
	output logic PORT_BUS_OE_O,
	input wire logic PERIPHERAL_HOLD_N_I,
	output logic DATA_STROBE_N_O,
	output logic ADDR_STROBE_N_O,
	output logic DIRECTION_OUT_N_O,
	output logic CTRL_STROBE_N_O,
	output logic CTRL_LINEFEED_OUT_N_O,
	output logic CTRL_INIT_O,
	output logic CTRL_SELECT_N_O
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	epc_pkg::epc_state_t state_q, state_d;
	logic [7:0] ctrl_q, spp_data_q, cfg_q, int_mask_q;
	logic [1:0] int_stat_q;
	logic timeout_q;
	logic mode19_q, epp_en_q;
	logic rd_prev_q, wr_prev_q;
	logic cyc_read_q, cyc_addr_q;
	logic [7:0] rd_byte_q, port_q;
	logic [7:0] rdata;
	logic wr_fire, rd_fire;
	logic rd_act, wr_act, host_sel, start, start_read, start_addr;
	logic wd_expired, cycle_done;
	logic strobe_on, r19_dir, port_direction_bit, control_direction_bit;
	epc_pkg::epc_reg_t wr_reg, rd_reg;

	assign rd_act = !HOST_RD_N_I;
	assign wr_act = !HOST_WR_N_I;
	// Ports 3..7 exist only with EPP enabled
	assign host_sel = epp_en_q && (HOST_ADDR_I >= `EPC_HOST_ADDR_PORT);
	assign start_read = rd_act && !rd_prev_q;
	assign start = host_sel && (start_read || (wr_act && !wr_prev_q));
	assign start_addr = (HOST_ADDR_I == `EPC_HOST_ADDR_PORT);
	assign control_direction_bit = ctrl_q[`EPC_CTRL_PCD];

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	epc_wb_slave u_wb (
		.clk_i(MCLK_I),
		.rst_n_i(RSTN_I),
		.cyc_i(WB_CYC_I),
		.stb_i(WB_STB_I),
		.we_i(WB_WE_I),
		.sel_i(WB_SEL_I),
		.ack_o(WB_ACK_O),
		.dat_o(WB_DAT_O),
		.rdata_i(rdata),
		.wr_fire_o(wr_fire),
		.rd_fire_o(rd_fire)
	);

	assign wr_reg = epc_pkg::epc_decode(WB_ADR_I);
	assign rd_reg = epc_pkg::epc_decode(WB_ADR_I);

	always_comb begin
		case (rd_reg)
			epc_pkg::EPC_R_CTRL: rdata = ctrl_q;
			epc_pkg::EPC_R_SPP_DATA: rdata = spp_data_q;
			epc_pkg::EPC_R_CONFIG: rdata = cfg_q;
			epc_pkg::EPC_R_STATUS: rdata = {6'h00, state_q != epc_pkg::EPC_ST_IDLE, timeout_q};
			epc_pkg::EPC_R_INT_STAT: rdata = {6'h00, int_stat_q};
			epc_pkg::EPC_R_INT_MASK: rdata = int_mask_q;
			epc_pkg::EPC_R_LAST_RD: rdata = rd_byte_q;
			epc_pkg::EPC_R_LAST_WR: rdata = port_q;
			default: rdata = 8'h00;
		endcase
	end

	// Bits 6 and 7 of control stay low
	always_ff @(posedge MCLK_I) begin
		if (!RSTN_I) begin
			ctrl_q <= `EPC_CTRL_RST;
		end else if (wr_fire && wr_reg == epc_pkg::EPC_R_CTRL) begin
			ctrl_q <= WB_DAT_I[7:0] & `EPC_CTRL_MASK;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!RSTN_I) begin
			spp_data_q <= `EPC_BYTE_RST;
		end else if (wr_fire && wr_reg == epc_pkg::EPC_R_SPP_DATA) begin
			spp_data_q <= WB_DAT_I[7:0];
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!RSTN_I) begin
			cfg_q <= `EPC_CFG_RST;
		end else if (wr_fire && wr_reg == epc_pkg::EPC_R_CONFIG) begin
			cfg_q <= WB_DAT_I[7:0] & `EPC_CFG_MASK;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!RSTN_I) begin
			int_mask_q <= 8'h00;
		end else if (wr_fire && wr_reg == epc_pkg::EPC_R_INT_MASK) begin
			int_mask_q <= WB_DAT_I[7:0] & `EPC_INT_MASK_BITS;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!RSTN_I) begin
			mode19_q <= 1'b0;
			epp_en_q <= 1'b0;
		end else if (state_q == epc_pkg::EPC_ST_IDLE && !start) begin
			mode19_q <= cfg_q[`EPC_CFG_V19];
			epp_en_q <= cfg_q[`EPC_CFG_EPP_EN];
		end
	end

	// ----------------------------------------
	// Events and interrupt
	// ----------------------------------------
	// timeout flag, read clears, set wins
	always_ff @(posedge MCLK_I) begin
		if (!RSTN_I) begin
			timeout_q <= 1'b0;
		end else if (wd_expired) begin
			timeout_q <= 1'b1;
		end else if (rd_fire && rd_reg == epc_pkg::EPC_R_STATUS) begin
			timeout_q <= 1'b0;
		end
	end

	// A new event in the clearing read stays set
	always_ff @(posedge MCLK_I) begin
		if (!RSTN_I) begin
			int_stat_q <= 2'h0;
		end else begin
			int_stat_q <= ((rd_fire && rd_reg == epc_pkg::EPC_R_INT_STAT) ? 2'h0 : int_stat_q)
				| {cycle_done, wd_expired};
		end
	end

	assign INT_O = |(int_stat_q & int_mask_q[1:0]);

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	// watches the host-strobe-terminated cycle
	epc_watchdog #(
		.LIMIT(WDOG_CYCLES),
		.CW(16)
	) u_wdog (
		.clk_i(MCLK_I),
		.rst_n_i(RSTN_I),
		.run_i(state_q == epc_pkg::EPC_ST_V17_CYCLE),
		.expired_o(wd_expired)
	);

	// ----------------------------------------
	// Cycle sequencer
	// ----------------------------------------
	always_ff @(posedge MCLK_I) begin
		if (!RSTN_I) begin
			rd_prev_q <= 1'b0;
			wr_prev_q <= 1'b0;
		end else begin
			rd_prev_q <= rd_act;
			wr_prev_q <= wr_act;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!RSTN_I) begin
			cyc_read_q <= 1'b0;
			cyc_addr_q <= 1'b0;
		end else if (state_q == epc_pkg::EPC_ST_IDLE && start) begin
			cyc_read_q <= start_read;
			cyc_addr_q <= start_addr;
		end
	end

	always_comb begin
		state_d = state_q;
		cycle_done = 1'b0;
		case (state_q)
			epc_pkg::EPC_ST_IDLE: begin
				if (start && start_read && mode19_q) begin
					// hold already low, go straight on
					// hold high, wait for it to drop
					state_d = PERIPHERAL_HOLD_N_I ? epc_pkg::EPC_ST_R19_WAIT_LOW : epc_pkg::EPC_ST_R19_SETUP;
				end else if (start) begin
					state_d = epc_pkg::EPC_ST_V17_CYCLE;
				end
			end
			epc_pkg::EPC_ST_R19_WAIT_LOW: begin
				if (!rd_act) begin
					state_d = epc_pkg::EPC_ST_IDLE;
				end else if (!PERIPHERAL_HOLD_N_I) begin
					state_d = epc_pkg::EPC_ST_R19_SETUP;
				end
			end
			// direction set one cycle before strobe
			epc_pkg::EPC_ST_R19_SETUP: state_d = epc_pkg::EPC_ST_R19_STROBE;
			epc_pkg::EPC_ST_R19_STROBE: begin
				if (PERIPHERAL_HOLD_N_I) begin
					state_d = epc_pkg::EPC_ST_R19_TERM;
				end
			end
			epc_pkg::EPC_ST_R19_TERM: begin
				if (!rd_act) begin
					state_d = epc_pkg::EPC_ST_IDLE;
					cycle_done = 1'b1;
				end
			end
			epc_pkg::EPC_ST_V17_CYCLE: begin
				if (wd_expired) begin
					state_d = epc_pkg::EPC_ST_END_WAIT;
				// host strobe end closes the cycle
				end else if (cyc_read_q ? !rd_act : !wr_act) begin
					state_d = epc_pkg::EPC_ST_IDLE;
					cycle_done = 1'b1;
				end
			end
			epc_pkg::EPC_ST_END_WAIT: begin
				if (!rd_act && !wr_act) begin
					state_d = epc_pkg::EPC_ST_IDLE;
				end
			end
			default: state_d = epc_pkg::EPC_ST_IDLE;
		endcase
	end

	always_ff @(posedge MCLK_I) begin
		if (!RSTN_I) begin
			state_q <= epc_pkg::EPC_ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------
	// Data paths
	// ----------------------------------------
	// byte latched as hold releases
	always_ff @(posedge MCLK_I) begin
		if (!RSTN_I) begin
			rd_byte_q <= `EPC_BYTE_RST;
		end else if (state_q == epc_pkg::EPC_ST_R19_STROBE && PERIPHERAL_HOLD_N_I) begin
			rd_byte_q <= PORT_BUS_I;
		end else if (state_q == epc_pkg::EPC_ST_V17_CYCLE && cyc_read_q && rd_act) begin
			// Tracks the bus so the last sample before strobe end is held
			rd_byte_q <= PORT_BUS_I;
		end
	end

	// host byte to the port bus
	// idle bus carries the plain data register
	always_ff @(posedge MCLK_I) begin
		if (!RSTN_I) begin
			port_q <= `EPC_BYTE_RST;
		end else if (state_q == epc_pkg::EPC_ST_IDLE && start && !start_read) begin
			port_q <= HOST_DATA_BUS_I;
		end else if (state_q == epc_pkg::EPC_ST_V17_CYCLE && !cyc_read_q) begin
			if (wr_act) begin
				port_q <= HOST_DATA_BUS_I;
			end
		end else if (state_q == epc_pkg::EPC_ST_IDLE) begin
			port_q <= spp_data_q;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign strobe_on = (state_q == epc_pkg::EPC_ST_V17_CYCLE) || (state_q == epc_pkg::EPC_ST_R19_STROBE);
	// read direction held through strobe and term
	assign r19_dir = (state_q == epc_pkg::EPC_ST_R19_SETUP) || (state_q == epc_pkg::EPC_ST_R19_STROBE)
		|| (state_q == epc_pkg::EPC_ST_R19_TERM);
	// direction follows control bit outside a 1.9 read
	assign port_direction_bit = r19_dir ? 1'b1 : control_direction_bit;

	assign DATA_STROBE_N_O = !(strobe_on && !cyc_addr_q);
	assign ADDR_STROBE_N_O = !(strobe_on && cyc_addr_q);
	assign DIRECTION_OUT_N_O = port_direction_bit;
	assign PORT_BUS_O = port_q;
	assign PORT_BUS_OE_O = !port_direction_bit;

	assign HOST_CHAN_READY_O = !(
		(state_q == epc_pkg::EPC_ST_IDLE && start && ((start_read && mode19_q) || !PERIPHERAL_HOLD_N_I))
		|| (state_q == epc_pkg::EPC_ST_R19_WAIT_LOW)
		|| (state_q == epc_pkg::EPC_ST_R19_SETUP)
		|| (state_q == epc_pkg::EPC_ST_R19_STROBE)
		|| (state_q == epc_pkg::EPC_ST_V17_CYCLE && !PERIPHERAL_HOLD_N_I && !wd_expired));

	assign HOST_DATA_BUS_O = rd_byte_q;
	assign HOST_DATA_BUS_OE_O = rd_act && cyc_read_q
		&& ((state_q == epc_pkg::EPC_ST_R19_TERM) || (state_q == epc_pkg::EPC_ST_V17_CYCLE));

	// printer control lines from control register
	assign CTRL_STROBE_N_O = !ctrl_q[`EPC_CTRL_STROBE];
	assign CTRL_LINEFEED_OUT_N_O = !ctrl_q[`EPC_CTRL_LINEFEED];
	assign CTRL_INIT_O = ctrl_q[`EPC_CTRL_INIT];
	assign CTRL_SELECT_N_O = !ctrl_q[`EPC_CTRL_SELECT];

endmodule

`default_nettype wire

/* epc_engine_chk.sv */
// Checker for the EPP cycle engine, bound to its top-level ports.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none

module epc_engine_chk #(
	parameter int WDOG_CYCLES = 1250
) (
	// Clock and reset
	input wire logic MCLK_I,
	input wire logic RSTN_I,
	// Register bus
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_ACK_O,
	// Host strobe port
	input wire logic HOST_RD_N_I,
	input wire logic HOST_WR_N_I,
	input wire logic HOST_CHAN_READY_O,
	// Peripheral port
	input wire logic PORT_BUS_OE_O,
	input wire logic [7:0] PORT_BUS_O,
	input wire logic [7:0] HOST_DATA_BUS_I,
	input wire logic PERIPHERAL_HOLD_N_I,
	input wire logic DATA_STROBE_N_O,
	input wire logic ADDR_STROBE_N_O,
	input wire logic DIRECTION_OUT_N_O
);
	default clocking cb @(posedge MCLK_I);
	endclocking
	default disable iff (!RSTN_I);

	wire logic stb_on = !DATA_STROBE_N_O || !ADDR_STROBE_N_O;
	logic [15:0] wcnt_q, scnt_q;

	// Length of the current strobe, either direction
	always_ff @(posedge MCLK_I) begin
		if (!RSTN_I || !stb_on) begin
			scnt_q <= 16'h0000;
		end else begin
			scnt_q <= scnt_q + 16'h0001;
		end
	end

	// Length of the current write strobe
	always_ff @(posedge MCLK_I) begin
		if (!RSTN_I || !stb_on || DIRECTION_OUT_N_O) begin
			wcnt_q <= 16'h0000;
		end else begin
			wcnt_q <= wcnt_q + 16'h0001;
		end
	end

	a_one_strobe: assert property (!(!DATA_STROBE_N_O && !ADDR_STROBE_N_O))
		else $error("both strobes low");
	a_read_tristate: assert property (stb_on && DIRECTION_OUT_N_O |-> !PORT_BUS_OE_O && $past(DIRECTION_OUT_N_O))
		else $error("port bus driven or direction late during read");
	a_write_drives: assert property (stb_on && !DIRECTION_OUT_N_O |-> PORT_BUS_OE_O && PORT_BUS_O == $past(HOST_DATA_BUS_I))
		else $error("host byte not driven during write");
	// Expiry cycle excluded: the timeout may release ready
	a_hold_extends: assert property (stb_on && !PERIPHERAL_HOLD_N_I && scnt_q < WDOG_CYCLES - 1 |-> !HOST_CHAN_READY_O)
		else $error("ready high while hold low");
	a_ready_cause: assert property (!HOST_CHAN_READY_O |-> !HOST_RD_N_I || !HOST_WR_N_I || !$past(HOST_RD_N_I))
		else $error("ready low outside a host cycle");
	a_strobe_ends: assert property (stb_on && ($rose(HOST_RD_N_I) || $rose(HOST_WR_N_I)) |-> ##[1:2] !stb_on)
		else $error("strobe outlives host strobe");
	a_wdog_bound: assert property (wcnt_q <= WDOG_CYCLES + 2)
		else $error("write strobe outlived the watchdog");
	a_ack_latency: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("ack not one cycle after request");
	a_ack_single: assert property ($rose(WB_ACK_O) |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
endmodule

bind epc_engine epc_engine_chk #(.WDOG_CYCLES(WDOG_CYCLES)) u_chk (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I),
	.WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .HOST_RD_N_I(HOST_RD_N_I),
	.HOST_WR_N_I(HOST_WR_N_I), .HOST_CHAN_READY_O(HOST_CHAN_READY_O), .PORT_BUS_OE_O(PORT_BUS_OE_O),
	.PORT_BUS_O(PORT_BUS_O), .HOST_DATA_BUS_I(HOST_DATA_BUS_I),
	.PERIPHERAL_HOLD_N_I(PERIPHERAL_HOLD_N_I), .DATA_STROBE_N_O(DATA_STROBE_N_O),
	.ADDR_STROBE_N_O(ADDR_STROBE_N_O), .DIRECTION_OUT_N_O(DIRECTION_OUT_N_O));
`default_nettype wire

/* epc_periph_model.sv */
// Behavioural EPP peripheral on the far side of the port bus.
// Assumes the bench muxes the port bus from both drivers.
`timescale 1ns/10ps
`default_nettype none

module epc_periph_model (
	// Clock
	input wire logic clk_i,
	// Strobes and bus from the engine
	input wire logic data_strobe_n_i,
	input wire logic addr_strobe_n_i,
	input wire logic direction_out_n_i,
	input wire logic [7:0] port_bus_i,
	// Bench control
	input wire logic idle_high_i,
	input wire logic stall_i,
	input wire logic [7:0] read_byte_i,
	// Peripheral outputs
	output logic peripheral_hold_n_o,
	output logic [7:0] port_bus_o,
	output logic [7:0] last_byte_o,
	output logic last_addr_o,
	output logic [15:0] cycles_o
);
	wire logic on = !data_strobe_n_i || !addr_strobe_n_i;
	logic [4:0] cnt_q;

	initial begin
		cnt_q = 5'h00;
		peripheral_hold_n_o = 1'b0;
		port_bus_o = 8'h00;
		cycles_o = 16'h0000;
	end

	always @(posedge clk_i) begin
		if (on) begin
			cnt_q <= cnt_q + 5'h01;
			if (direction_out_n_i && cnt_q == 5'h01) begin
				port_bus_o <= read_byte_i;
			end
			peripheral_hold_n_o <= (cnt_q >= 5'h02) && !stall_i;
			if (!direction_out_n_i) begin
				last_byte_o <= port_bus_i;
				last_addr_o <= !addr_strobe_n_i;
			end
		end else begin
			if (cnt_q != 5'h00) begin
				cycles_o <= cycles_o + 16'h0001;
			end
			cnt_q <= 5'h00;
			port_bus_o <= ~port_bus_o;
			peripheral_hold_n_o <= idle_high_i;
		end
	end
endmodule
`default_nettype wire

/* epc_engine_bench.sv */
// Self-checking bench of the EPP cycle engine with a peripheral model.
// Assumes a short watchdog count so that the timeout case stays quick.
`timescale 1ns/10ps
`default_nettype none

module epc_engine_bench;
	typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [4:0] c;} epc_row_t;
	logic clk, rstn, we, cyc, stb, ack, irq, h_rd, h_wr, h_oe, rdy, p_oe, hold_n;
	logic dstb, astb, dir_n, c_stb, c_lf, c_init, c_sel, idle_hi, stall, m_addr;
	logic [7:0] adr, h_di, h_do, p_o, m_d, m_last, rd_byte, q;
	logic [2:0] h_adr;
	logic [31:0] wdat, rdat, r;
	logic [15:0] m_ncyc, n0;
	int n_mismatch = 0, total_checks = 0;
	epc_row_t rows [10];
	wire logic [7:0] p_i = p_oe ? p_o : m_d;
	wire logic [4:0] ctl = {c_stb, c_lf, c_init, c_sel, dir_n};

	epc_engine #(.WDOG_CYCLES(20)) dut (.MCLK_I(clk), .RSTN_I(rstn), .WB_ADR_I(adr), .WB_DAT_I(wdat),
		.WB_SEL_I(4'hF), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_ACK_O(ack), .WB_DAT_O(rdat),
		.INT_O(irq), .HOST_ADDR_I(h_adr), .HOST_RD_N_I(h_rd), .HOST_WR_N_I(h_wr), .HOST_DATA_BUS_I(h_di),
		.HOST_DATA_BUS_O(h_do), .HOST_DATA_BUS_OE_O(h_oe), .HOST_CHAN_READY_O(rdy), .PORT_BUS_I(p_i),
		.PORT_BUS_O(p_o), .PORT_BUS_OE_O(p_oe), .PERIPHERAL_HOLD_N_I(hold_n), .DATA_STROBE_N_O(dstb),
		.ADDR_STROBE_N_O(astb), .DIRECTION_OUT_N_O(dir_n), .CTRL_STROBE_N_O(c_stb),
		.CTRL_LINEFEED_OUT_N_O(c_lf), .CTRL_INIT_O(c_init), .CTRL_SELECT_N_O(c_sel));

	epc_periph_model u_per (.clk_i(clk), .data_strobe_n_i(dstb), .addr_strobe_n_i(astb),
		.direction_out_n_i(dir_n), .port_bus_i(p_i), .idle_high_i(idle_hi), .stall_i(stall),
		.read_byte_i(rd_byte), .peripheral_hold_n_o(hold_n), .port_bus_o(m_d), .last_byte_o(m_last),
		.last_addr_o(m_addr), .cycles_o(m_ncyc));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] rd);
		int n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h000000, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		chk(n < 50, 1);
	endtask

	// Host holds its strobe eight cycles, then until ready
	task automatic host(input logic rd, input logic [2:0] a, input logic [7:0] d, output logic [7:0] hq);
		int n = 0;
		@(posedge clk);
		h_adr <= a;
		h_di <= d;
		h_rd <= !rd;
		h_wr <= rd;
		repeat (8) @(posedge clk);
		while (rdy !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		hq = h_oe ? h_do : 8'h00;
		h_rd <= 1'b1;
		h_wr <= 1'b1;
		chk(n < 200, 1);
		repeat (3) @(posedge clk);
	endtask

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial begin
		#160000;
		n_mismatch++;
		give_verdict();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{rstn, we, cyc, stb, idle_hi, stall} = 6'h00;
		{h_rd, h_wr} = 2'h3;
		{adr, h_di, rd_byte, h_adr, wdat} = '0;
		rows = '{'{1, 8'h00, 8'hFF, 5'h05}, '{0, 8'h00, 8'h3F, 5'h05}, '{1, 8'h00, 8'h00, 5'h1A},
			'{0, 8'h20, 8'h00, 5'h1A}, '{1, 8'h14, 8'h03, 5'h1A}, '{0, 8'h14, 8'h03, 5'h1A},
			'{1, 8'h08, 8'h01, 5'h1A}, '{0, 8'h08, 8'h01, 5'h1A}, '{0, 8'h0C, 8'h00, 5'h1A},
			'{0, 8'h10, 8'h00, 5'h1A}};
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk({irq, ack, rdy, h_oe, p_oe, ctl}, 10'h0BA);
		foreach (rows[i]) begin
			wb(rows[i].w, rows[i].a, rows[i].d, r);
			@(posedge clk);
			if (!rows[i].w) chk(r, rows[i].d);
			chk(ctl, rows[i].c);
		end
		host(0, 3'h5, 8'hA5, q);
		chk({m_last, m_addr, irq}, 10'h295);
		wb(1, 8'h14, 8'h01, r);
		@(posedge clk);
		chk(irq, 0);
		wb(0, 8'h10, 8'h00, r);
		chk(r, 2);
		host(0, 3'h3, 8'h3C, q);
		chk({m_last, m_addr}, 9'h079);
		n0 = m_ncyc;
		host(0, 3'h2, 8'h77, q);
		chk(m_ncyc, n0);
		wb(1, 8'h04, 8'h6E, r);
		wb(0, 8'h1C, 8'h00, r);
		chk(r, 8'h6E);
		// read direction, D0 D1 D3 clear
		wb(1, 8'h00, 8'h20, r);
		rd_byte <= 8'h96;
		host(1, 3'h4, 8'h00, q);
		chk(q, 8'h96);
		wb(0, 8'h18, 8'h00, r);
		chk(r, 8'h96);
		wb(1, 8'h00, 8'h00, r);
		stall <= 1'b1;
		host(0, 3'h4, 8'h11, q);
		stall <= 1'b0;
		chk(irq, 1);
		wb(0, 8'h0C, 8'h00, r);
		chk(r, 1);
		wb(0, 8'h0C, 8'h00, r);
		chk(r, 0);
		wb(1, 8'h08, 8'h03, r);
		idle_hi <= 1'b1;
		rd_byte <= 8'h5A;
		fork
			host(1, 3'h4, 8'h00, q);
			begin
				repeat (5) @(posedge clk);
				chk({dstb, rdy}, 2'h2);
				idle_hi <= 1'b0;
			end
		join
		chk(q, 8'h5A);
		rd_byte <= 8'hC3;
		host(1, 3'h4, 8'h00, q);
		chk(q, 8'hC3);
		// Reset in mid-run returns the idle port state
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk({irq, ack, rdy, h_oe, p_oe, ctl}, 10'h0BA);
		give_verdict();
	end
endmodule
`default_nettype wire
